// >>> bench/sad_slave_model.sv
`timescale 1ns/10ps
`include "sad_defs.svh"
// ****************************************
// Slave side stand-in
// ****************************************
module sad_slave_model (
  input  wire logic                    mclk,
  input  wire logic                    nrst,
  input  wire logic                    slow,
  input  wire logic                    hready,
  input  wire logic [`SAD_NTGT-1:0]    tgtSel,
  output logic      [`SAD_NTGT-1:0]    slvReady,
  output logic      [`SAD_NTGT-1:0]    slvResp,
  output logic      [`SAD_NTGT*32-1:0] slvRdata
);
  logic [`SAD_NTGT-1:0] dpT_ff;
  logic                 wt_ff;
  logic [31:0]          cnt_ff;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      dpT_ff <= '0;
      wt_ff  <= 1'b0;
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
      dpT_ff <= hready ? tgtSel : dpT_ff;
      wt_ff  <= hready & slow & (|tgtSel);
    end
  end
  // Slow answers add one wait; unselected data toggles so stale data never matches
  always_comb begin
    slvReady = ~(dpT_ff & {`SAD_NTGT{wt_ff}});
    slvResp  = '0;
    for (int i = 0; i < `SAD_NTGT; i++) begin
      slvRdata[i*32+:32] = (dpT_ff[i] && slvReady[i]) ? (32'h5a00_0000 | 32'(i)) : ~cnt_ff;
    end
  end
endmodule : sad_slave_model

// >>> bench/test_system_address_decoder.sv
`timescale 1ns/10ps
`include "sad_defs.svh"
// ****************************************
// Decoder bench
// ****************************************
module test_system_address_decoder;
  typedef struct {logic [8:0] tgt; logic [31:0] adr; logic err; logic f; logic [31:0] rd;} sad_exp_t;
  logic                    mclk = 1'b0;
  logic                    nrst = 1'b0;
  logic [31:0]             haddr = '0;
  logic [1:0]              htrans = '0;
  logic                    hwrite = 1'b0;
  logic [2:0]              hsize = 3'h2;
  logic [3:0]              hprot = 4'h1;
  logic [1:0]              shadowSel = '0;
  logic                    slow = 1'b0;
  logic [31:0]             rnd = 32'd66790;
  logic [`SAD_NTGT-1:0]    slvReady, slvResp, tgtSel;
  logic [`SAD_NTGT*32-1:0] slvRdata;
  logic [31:0]             slvAddr, hrdata;
  logic [2:0]              slvSize;
  logic [4:0]              slotIdx;
  logic                    hreadyOut, hresp, fetchAbort, dataAbort;
  int                      fails = 0;
  int                      nTests = 0;
  sad_exp_t                aq[$], dq[$];
  localparam logic [31:0] MAP [26] = '{32'h2020_0000, 32'h6000_0000, 32'ha000_0000, 32'hbfff_f000, 32'he000_6000,
    32'he000_7000, 32'he000_8000, 32'he000_a000, 32'he000_b000, 32'he004_7000, 32'he004_8000, 32'he006_0000,
    32'he008_c000, 32'he008_d000, 32'hffff_f000, 32'hffff_e000, 32'h4000_0000, 32'h8000_0000, 32'hc000_0000,
    32'h2030_0000, 32'h6008_0000, 32'h2000_0000, 32'he004_4000, 32'he004_3000, 32'he008_7000, 32'he008_0000};
  localparam int TGT [26] = '{1, 2, 3, 4, 5, 9, 5, 5, 9, 6, 9, 9, 7, 9, 8, 9, 9, 9, 9, 9, 9, 0, 6, 6, 7, 7};
  always #20 mclk = ~mclk;
  sad_decoder sad_decoder_inst (.mclk(mclk), .nrst(nrst), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hprot(hprot), .hready(hreadyOut), .shadowSel(shadowSel), .slvReady(slvReady),
    .slvResp(slvResp), .slvRdata(slvRdata), .tgtSel(tgtSel), .slvAddr(slvAddr), .slvSize(slvSize),
    .slotIdx(slotIdx), .hreadyOut(hreadyOut), .hresp(hresp), .hrdata(hrdata), .fetchAbort(fetchAbort),
    .dataAbort(dataAbort));
  sad_slave_model sad_slave_model_inst (.mclk(mclk), .nrst(nrst), .slow(slow), .hready(hreadyOut),
    .tgtSel(tgtSel), .slvReady(slvReady), .slvResp(slvResp), .slvRdata(slvRdata));
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return x[0] ? ((x >> 1) ^ 32'h8020_0003) : (x >> 1);
  endfunction : nxt
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    nTests++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic report_and_stop;
    if (fails == 0 && nTests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // Called just after a rising edge; returns just after the edge that takes the request
  task automatic xfer(input logic [31:0] a, input logic [31:0] ea, input int t, input logic f, input logic bw);
    sad_exp_t e;
    int n;
    e.tgt = (t < 9) ? (9'h1 << t) : 9'h0;
    e.adr = bw ? {ea[31:2], 2'h0} : ea;
    e.err = (t > 8);
    e.f = f;
    e.rd = 32'h5a00_0000 | 32'(t);
    aq.push_back(e);
    rnd = nxt(rnd);
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= bw;
    hsize <= bw ? 3'h0 : 3'h2;
    hprot <= {3'h0, ~f};
    slow <= rnd[0];
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (hreadyOut !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      report_and_stop();
    end
    @(posedge mclk);
  endtask : xfer
  // Outputs are settled at the falling edge
  always @(negedge mclk) begin
    if (nrst) begin
      if (dq.size() > 0) begin
        cmp(32'({fetchAbort, dataAbort}), 32'((hreadyOut === 1'b0 && dq[0].err) ? {dq[0].f, ~dq[0].f} : 2'h0));
        cmp(32'(hresp), 32'(dq[0].err));
        if (hreadyOut === 1'b1) begin
          if (!dq[0].err) cmp(hrdata, dq[0].rd);
          void'(dq.pop_front());
        end
      end else begin
        cmp(32'({hreadyOut, hresp, fetchAbort, dataAbort}), 32'h8);
      end
      if (htrans[1] && hreadyOut === 1'b1 && aq.size() > 0) begin
        cmp(32'(tgtSel), 32'(aq[0].tgt));
        cmp(32'(slotIdx), 32'(aq[0].adr[16:12]));
        if (!aq[0].err) cmp(slvAddr, aq[0].adr);
        if (!aq[0].err) cmp(32'(slvSize), 32'h2);
        dq.push_back(aq.pop_front());
      end else begin
        cmp(32'(tgtSel), 32'h0);
      end
    end
  end
  initial begin
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    // Vector walk cycles the shadow source; select value 3 falls back to flash
    for (int v = 0; v < 8; v++) begin
      shadowSel <= 2'(v);
      xfer(32'(v * 4), (v % 4 == 1 ? `SAD_SRAM_BASE : v % 4 == 2 ? `SAD_EXT_BASE : `SAD_FLASH_BASE) | 32'(v * 4),
        v % 4 == 1 ? 2 : v % 4 == 2 ? 3 : 0, 1'b0, 1'b0);
    end
    // Pass 0 data with random byte writes, pass 1 fetches; random offsets stay in the slot
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 26; i++) begin
        logic bw;
        logic [31:0] a;
        bw = rnd[2] && p == 0;
        a = MAP[i] | (rnd & (bw ? 32'hfff : 32'hffc));
        xfer(a, a, TGT[i], p[0], bw);
      end
    end
    htrans <= 2'h0;
    for (int n = 0; n < 50 && dq.size() + aq.size() > 0; n++) @(posedge mclk);
    if (dq.size() + aq.size() > 0) fails++;
    report_and_stop();
  end
endmodule : test_system_address_decoder

// >>> core/sad_decoder.sv
`timescale 1ns/10ps
`include "sad_defs.svh"
module sad_decoder #(
  parameter logic [31:0] GEN_SLOTS = `SAD_GEN_SLOTS,
  parameter logic [31:0] PER_SLOTS = `SAD_PER_SLOTS,
  parameter logic [31:0] NET_SLOTS = `SAD_NET_SLOTS
) (
  input  wire logic                       mclk,
  input  wire logic                       nrst,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [3:0]                 hprot,
  input  wire logic                       hready,
  input  wire logic [1:0]                 shadowSel,
  input  wire logic [`SAD_NTGT-1:0]       slvReady,
  input  wire logic [`SAD_NTGT-1:0]       slvResp,
  input  wire logic [`SAD_NTGT*32-1:0]    slvRdata,
  output logic      [`SAD_NTGT-1:0]       tgtSel,
  output logic      [31:0]                slvAddr,
  output logic      [2:0]                 slvSize,
  output logic      [4:0]                 slotIdx,
  output logic                            hreadyOut,
  output logic                            hresp,
  output logic      [31:0]                hrdata,
  output logic                            fetchAbort,
  output logic                            dataAbort
);
  // ****************************************
  // Address phase decode
  // ****************************************
  function automatic logic slot_ok(input logic [31:0] mask, input logic [4:0] s);
    slot_ok = mask[s];
  endfunction : slot_ok

  logic        xfer;
  logic [31:0] effAddr;
  logic        unmapped;
  logic [4:0]  slot;

  assign xfer = htrans[1] & hready;
  assign slot = haddr[16:12];

  always_comb begin
    tgtSel   = '0;
    effAddr  = haddr;
    unmapped = 1'b0;
    // Shadow area resolves to the chosen region first, so vectors follow it
    if (haddr[31:29] == `SAD_REG_SHADOW) begin
      if (shadowSel == `SAD_SH_SRAM) begin
        effAddr = `SAD_SRAM_BASE | {3'h0, haddr[28:0]};
      end else if (shadowSel == `SAD_SH_EXT) begin
        effAddr = `SAD_EXT_BASE | {3'h0, haddr[28:0]};
      end else begin
        effAddr = `SAD_FLASH_BASE | {3'h0, haddr[28:0]};
      end
    end
    if (effAddr[31:29] == `SAD_REG_FLASH && effAddr[28:21] == 8'h00) begin
      tgtSel[`SAD_T_FLASH] = 1'b1;
    end else if (effAddr[31:12] == 20'(`SAD_FLASH_CFG >> 12)) begin
      tgtSel[`SAD_T_FCFG] = 1'b1;
    end else if (effAddr[31:29] == `SAD_REG_SRAM && effAddr[28:19] == 10'h000) begin
      tgtSel[`SAD_T_SRAM] = 1'b1;
    end else if (effAddr[31:12] == 20'(`SAD_SMC_CFG >> 12)) begin
      tgtSel[`SAD_T_SMC] = 1'b1;
    end else if (effAddr[31:29] == `SAD_REG_EXT) begin
      tgtSel[`SAD_T_EXT] = 1'b1;
    end else if (effAddr[31:17] == 15'(`SAD_GEN_BASE >> 17)) begin
      tgtSel[`SAD_T_GEN] = slot_ok(GEN_SLOTS, slot);
      unmapped           = ~slot_ok(GEN_SLOTS, slot);
    end else if (effAddr[31:17] == 15'(`SAD_PER_BASE >> 17)) begin
      tgtSel[`SAD_T_PER] = slot_ok(PER_SLOTS, slot);
      unmapped           = ~slot_ok(PER_SLOTS, slot);
    end else if (effAddr[31:17] == 15'(`SAD_NET_BASE >> 17)) begin
      tgtSel[`SAD_T_NET] = slot_ok(NET_SLOTS, slot);
      unmapped           = ~slot_ok(NET_SLOTS, slot);
    end else if (effAddr[31:12] == 20'(`SAD_VIC_BASE >> 12)) begin
      tgtSel[`SAD_T_VIC] = 1'b1;
    end else begin
      unmapped = 1'b1;
    end
    if (!xfer) begin
      tgtSel = '0;
    end
  end

  // Only slot offset matters to a peripheral; higher bits are not checked there
  assign slotIdx = slot;

  always_comb begin
    slvAddr = effAddr;
    slvSize = hsize;
    // Byte writes widen to a word so the slave never sees a size it may refuse
    if (hwrite && hsize == 3'h0) begin
      slvSize = 3'h2;
      slvAddr = {effAddr[31:2], 2'h0};
    end
  end

  // ****************************************
  // Data phase: error slave and response mux
  // ****************************************
  sad_pkg::sad_err_t            state_ff;
  sad_pkg::sad_err_t            nxt_state;
  logic [`SAD_NTGT-1:0]         dsel_ff;
  logic [`SAD_NTGT-1:0]         nxt_dsel;
  logic                         fetch_ff;
  logic                         nxt_fetch;

  always_comb begin
    nxt_state = state_ff;
    nxt_dsel  = dsel_ff;
    nxt_fetch = fetch_ff;
    case (state_ff)
      sad_pkg::SAD_IDLE: begin
        if (hready) begin
          nxt_dsel = tgtSel;
        end
        if (xfer && unmapped) begin
          nxt_state = sad_pkg::SAD_ERR1;
          nxt_fetch = ~hprot[0];
        end
      end
      sad_pkg::SAD_ERR1: begin
        nxt_state = sad_pkg::SAD_ERR2;
      end
      sad_pkg::SAD_ERR2: begin
        // Ready shows again here, so a transfer the master did not cancel is taken now
        nxt_state = sad_pkg::SAD_IDLE;
        nxt_dsel  = hready ? tgtSel : '0;
        if (xfer && unmapped) begin
          nxt_state = sad_pkg::SAD_ERR1;
          nxt_fetch = ~hprot[0];
        end
      end
      default: begin
        nxt_state = sad_pkg::SAD_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_ff <= sad_pkg::SAD_IDLE;
      dsel_ff  <= '0;
      fetch_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      dsel_ff  <= nxt_dsel;
      fetch_ff <= nxt_fetch;
    end
  end

  // The core holds the fetch flag in its pipeline; aborting is its call
  assign fetchAbort = (state_ff == sad_pkg::SAD_ERR1) & fetch_ff;
  assign dataAbort  = (state_ff == sad_pkg::SAD_ERR1) & ~fetch_ff;

  // Mapped slaves answer for themselves, so undefined offsets do not abort
  always_comb begin
    hreadyOut = 1'b1;
    hresp     = 1'b0;
    hrdata    = '0;
    if (state_ff == sad_pkg::SAD_ERR1) begin
      hreadyOut = 1'b0;
      hresp     = 1'b1;
    end else if (state_ff == sad_pkg::SAD_ERR2) begin
      hresp = 1'b1;
    end else begin
      for (int i = 0; i < `SAD_NTGT; i++) begin
        if (dsel_ff[i]) begin
          hreadyOut = slvReady[i];
          hresp     = slvResp[i];
          hrdata    = slvRdata[i*32 +: 32];
        end
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_err_two_cycle: assert property (xfer && unmapped && state_ff == sad_pkg::SAD_IDLE |=>
    (!hreadyOut && hresp) ##1 (hreadyOut && hresp)) else $error("Error response not two cycles");
  a_unmapped_nosel: assert property (unmapped |-> tgtSel == '0)
    else $error("Unmapped address selected a slave");
  a_onehot_sel: assert property ($onehot0(tgtSel))
    else $error("More than one slave selected");
  a_vic_slot: assert property (xfer && haddr[31:12] == 20'hfffff |-> tgtSel[`SAD_T_VIC])
    else $error("Interrupt controller not selected");
  a_shadow_flash: assert property (xfer && haddr <= `SAD_VEC_LAST && shadowSel == `SAD_SH_FLASH
    |-> tgtSel[`SAD_T_FLASH]) else $error("Vectors not served from flash");
  a_byte_write: assert property (hwrite && hsize == 3'h0 |-> slvSize == 3'h2 && slvAddr[1:0] == 2'h0)
    else $error("Byte write not widened");
  a_fetch_abort: assert property (xfer && unmapped && !hprot[0] && state_ff == sad_pkg::SAD_IDLE
    |=> fetchAbort && !dataAbort) else $error("Fetch abort not flagged");
  a_gen_hole: assert property (xfer && haddr[31:12] == 20'he0007 |=> !hreadyOut && hresp)
    else $error("Unassigned slot did not abort");
  a_net_lin: assert property (xfer && haddr[31:12] == 20'he008c |-> tgtSel[`SAD_T_NET] && slotIdx == 5'h0c)
    else $error("Last LIN slot not decoded");
  a_mapped_pass: assert property (dsel_ff[`SAD_T_PER] && state_ff == sad_pkg::SAD_IDLE
    |-> hresp == slvResp[`SAD_T_PER]) else $error("Mapped slot response overridden");

  // ****************************************
  // Map checks
  // ****************************************
  a_flash_data: assert property (xfer && haddr[31:21] == 11'h100
    |-> tgtSel[`SAD_T_FLASH])
    else $error("Flash data not selected");
  a_flash_cfg: assert property (xfer && haddr[31:12] == 20'h20200
    |-> tgtSel[`SAD_T_FCFG])
    else $error("Flash config not selected");
  a_sram_data: assert property (xfer && haddr[31:19] == 13'h0c00
    |-> tgtSel[`SAD_T_SRAM])
    else $error("SRAM not selected");
  a_smc_cfg: assert property (xfer && haddr[31:12] == 20'hbffff
    |-> tgtSel[`SAD_T_SMC])
    else $error("Static memory config not selected");
  a_ext_mem: assert property (xfer && haddr[31:29] == 3'h5 && haddr[31:12] != 20'hbffff
    |-> tgtSel[`SAD_T_EXT])
    else $error("External memory not selected");
  a_reserved_region: assert property (xfer && (haddr[31:29] == 3'h2 || haddr[31:29] == 3'h4 || haddr[31:29] == 3'h6)
    |=> !hreadyOut && hresp)
    else $error("Reserved region did not abort");
  a_cluster_gap: assert property (xfer && haddr[31:17] == 15'h7003
    |-> unmapped && tgtSel == '0)
    else $error("Gap between clusters was decoded");
  a_gen_watchdog: assert property (xfer && haddr[31:12] == 20'he0006
    |-> tgtSel[`SAD_T_GEN] && slotIdx == 5'h06)
    else $error("Watchdog slot not decoded");
  a_gen_router: assert property (xfer && haddr[31:12] == 20'he0008
    |-> tgtSel[`SAD_T_GEN] && slotIdx == 5'h08)
    else $error("Event router slot not decoded");
  a_gen_spare: assert property (xfer && haddr[31:12] == 20'he000b
    |-> unmapped && tgtSel == '0)
    else $error("Spare general slot was decoded");
  a_per_timer: assert property (xfer && haddr[31:12] == 20'he0043
    |-> tgtSel[`SAD_T_PER] && slotIdx == 5'h03)
    else $error("Last timer slot not decoded");
  a_per_uart: assert property (xfer && haddr[31:12] == 20'he0044
    |-> tgtSel[`SAD_T_PER] && slotIdx == 5'h04)
    else $error("Serial port slot not decoded");
  a_per_hole: assert property (xfer && haddr[31:12] == 20'he0048
    |=> !hreadyOut && hresp)
    else $error("Spare peripheral slot did not abort");
  a_net_can: assert property (xfer && haddr[31:12] == 20'he0080
    |-> tgtSel[`SAD_T_NET] && slotIdx == 5'h00)
    else $error("First CAN slot not decoded");
  a_net_filter: assert property (xfer && haddr[31:12] == 20'he0087
    |-> tgtSel[`SAD_T_NET] && slotIdx == 5'h07)
    else $error("Filter slot not decoded");
  a_net_hole: assert property (xfer && haddr[31:12] == 20'he008d
    |-> unmapped && tgtSel == '0)
    else $error("Spare network slot was decoded");
  a_vic_alone: assert property (xfer && haddr[31:12] == 20'hffffe
    |-> unmapped && tgtSel == '0)
    else $error("Space below interrupt controller was decoded");
  a_shadow_sram: assert property (xfer && haddr[31:19] == 13'h0000 && shadowSel == `SAD_SH_SRAM
    |-> tgtSel[`SAD_T_SRAM])
    else $error("Shadow area not served from SRAM");
  a_shadow_ext: assert property (xfer && haddr <= `SAD_VEC_LAST && shadowSel == `SAD_SH_EXT
    |-> tgtSel[`SAD_T_EXT])
    else $error("Vectors not served from external memory");
  a_data_abort: assert property (xfer && unmapped && hprot[0]
    |=> dataAbort && !fetchAbort)
    else $error("Data abort not flagged");
  a_abort_pulse: assert property (dataAbort || fetchAbort
    |=> !dataAbort && !fetchAbort)
    else $error("Abort flag held too long");
  a_err_back2back: assert property (state_ff == sad_pkg::SAD_ERR2 && xfer && unmapped
    |=> !hreadyOut && hresp && (fetchAbort || dataAbort))
    else $error("Error after error not answered");
  a_idle_ready: assert property (state_ff == sad_pkg::SAD_IDLE && dsel_ff == '0
    |-> hreadyOut && !hresp && hrdata == '0)
    else $error("Idle data phase not ready");
  a_byte_keep: assert property (!(hwrite && hsize == 3'h0)
    |-> slvSize == hsize)
    else $error("Size changed on a non-byte transfer");

  c_data_abort: cover property (dataAbort);
  c_fetch_abort: cover property (fetchAbort);
  c_sram_shadow: cover property (xfer && haddr[31:29] == 3'h0 && tgtSel[`SAD_T_SRAM]);
  c_smc_cfg: cover property (tgtSel[`SAD_T_SMC]);
  c_err_back2back: cover property (state_ff == sad_pkg::SAD_ERR2 && xfer && unmapped);
endmodule : sad_decoder

// >>> core/sad_defs.svh
`ifndef SAD_DEFS_SVH
`define SAD_DEFS_SVH
// ****************************************
// Memory map
// ****************************************
`define SAD_REG_SHADOW     3'h0
`define SAD_REG_FLASH      3'h1
`define SAD_REG_SRAM       3'h3
`define SAD_REG_EXT        3'h5
`define SAD_REG_PERIPH     3'h7
`define SAD_FLASH_BASE     32'h2000_0000
`define SAD_FLASH_CFG      32'h2020_0000
`define SAD_SRAM_BASE      32'h6000_0000
`define SAD_EXT_BASE       32'ha000_0000
`define SAD_SMC_CFG        32'hbfff_f000
`define SAD_GEN_BASE       32'he000_0000
`define SAD_PER_BASE       32'he004_0000
`define SAD_NET_BASE       32'he008_0000
`define SAD_VIC_BASE       32'hffff_f000
`define SAD_VEC_LAST       32'h0000_001c
`define SAD_VEC_PABT       32'h0000_000c
`define SAD_VEC_DABT       32'h0000_0010
`define SAD_GEN_SLOTS      32'h0000_057f
`define SAD_PER_SLOTS      32'h0000_00ff
`define SAD_NET_SLOTS      32'h0000_1fff
// ****************************************
// Target select bit positions, target count and shadow select codes
// ****************************************
`define SAD_T_FLASH        0
`define SAD_T_FCFG         1
`define SAD_T_SRAM         2
`define SAD_T_EXT          3
`define SAD_T_SMC          4
`define SAD_T_GEN          5
`define SAD_T_PER          6
`define SAD_T_NET          7
`define SAD_T_VIC          8
`define SAD_NTGT           9
`define SAD_SH_FLASH       2'h0
`define SAD_SH_SRAM        2'h1
`define SAD_SH_EXT         2'h2
`endif

// >>> core/sad_pkg.sv
package sad_pkg;
  typedef enum logic [2:0] {
    SAD_IDLE = 3'b001,
    SAD_ERR1 = 3'b010,
    SAD_ERR2 = 3'b100
  } sad_err_t;
endpackage : sad_pkg
